// ---- asrb_pkg.sv ----
// Constants for the asynchronous serial block: register map, bit fields, resets, timing.
// Assumes an 8-bit register port and a 250 MHz core clock feeding the bit-rate dividers.
package asrb_pkg;
	// Register addresses on the plain register port
	localparam logic [7:0] ADDR_FLAG = 8'h50;
	localparam logic [7:0] ADDR_DATA = 8'h51;
	localparam logic [7:0] ADDR_BAUD = 8'h52;
	localparam logic [7:0] ADDR_CHAR = 8'h53;
	localparam logic [7:0] ADDR_IRQ = 8'h54;
	localparam logic [7:0] ADDR_RXFINE = 8'h55;
	localparam logic [7:0] ADDR_TXFINE = 8'h57;

	// Flag vector index; flag_bank bit = index + 1, bit 0 reads zero
	localparam int F_VAC = 6;
	localparam int F_DONE = 5;
	localparam int F_FULL = 4;
	localparam int F_IDLE = 3;
	localparam int F_LOST = 2;
	localparam int F_NOISE = 1;
	localparam int F_FRAME = 0;
	localparam logic [6:0] RX_FLAG_MASK = 7'h1f;
	localparam logic [6:0] TX_FLAG_MASK = 7'h60;

	// char_ctl fields
	localparam int C_RX9 = 7;
	localparam int C_TX9 = 6;
	localparam int C_NINE = 4;
	localparam int C_ROUSE = 3;

	// irq_ctl fields
	localparam int I_TXVOID = 7;
	localparam int I_TXDONE = 6;
	localparam int I_RX = 5;
	localparam int I_IDLE = 4;
	localparam int I_TXON = 3;
	localparam int I_RXON = 2;
	localparam int I_SILENT = 1;
	localparam int I_BRK = 0;

	// baud_div fields
	localparam int B_PRE_HI = 7;
	localparam int B_PRE_LO = 6;
	localparam int B_TX_HI = 5;
	localparam int B_TX_LO = 3;
	localparam int B_RX_HI = 2;
	localparam int B_RX_LO = 0;

	// Reset values
	localparam logic [7:0] FLAG_RST = 8'hc0;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] CHAR_RST = 8'h00;
	localparam logic [7:0] FINE_RST = 8'h00;

	// First prescaler factors, selected by baud_first_div
	localparam logic [11:0] PRE_F0 = 12'h001;
	localparam logic [11:0] PRE_F1 = 12'h003;
	localparam logic [11:0] PRE_F2 = 12'h004;
	localparam logic [11:0] PRE_F3 = 12'h00d;

	// Bit timing: 16 sub-ticks per bit; conventional rate is 32 x, so 2 core clocks per
	// first-prescaler unit per sub-tick
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SUB_S0 = 4'h7;
	localparam logic [3:0] SUB_S1 = 4'h8;
	localparam logic [3:0] SUB_S2 = 4'h9;
	localparam int CONV_SHIFT = 1;
	localparam logic [3:0] FRAME_BITS8 = 4'ha;
	localparam logic [3:0] FRAME_BITS9 = 4'hb;
	localparam logic [3:0] DATA_LAST8 = 4'h7;
	localparam logic [3:0] DATA_LAST9 = 4'h8;
	localparam logic [7:0] IDLE_SUBS8 = 8'ha0;
	localparam logic [7:0] IDLE_SUBS9 = 8'hb0;
endpackage

// ---- asrb_top.sv ----
// Asynchronous serial transceiver with flag bank, frame control, data port and bit-rate dividers.
// Assumes a register master on clock_i and a remote transceiver on the rx and tx pins.
//
// What this block does
// - Set tx_buf_vacant when holding data moves to shift register; clear by flag read, data write.
// - Never move holding data to the shift register while tx_buf_vacant is set.
// - Set tx_done after any data, preamble or break frame; clear by flag read, data write.
// - Set rx_full when a word reaches rx_holding_buf; clear on rx_on low or read sequence.
// - Idle flag sets once per received word, never on an idle that wakes the receiver.
// - Word arriving while rx_full set raises rx_lost_flag; holding buffer keeps old word.
// - Noise on a frame sets noise_flag together with rx_full, no own interrupt.
// - Bad stop or break sets framing_flag; with overrun only rx_lost_flag is set.
// - rx_on low clears all receive flags; flag read then data read clears them too.
// - One interrupt output from the four enables and their flags.
// - Frame is start bit, eight or nine data bits, one stop bit.
// - Ninth received bit goes to rx_ninth_bit; ninth sent bit comes from tx_ninth_bit.
// - rouse_kind selects wake on idle line (0) or address mark (1).
// - tx_on enables transmitter and hands the tx pin to the serial function.
// - tx_on low then high during a frame queues a preamble after it.
// - rx_on enables receiver, which hunts for a start bit.
// - rx_silent mutes the receiver; hardware clears it on the wake-up event.
// - brk_send high sends breaks; a pulse on it sends one break after current word.
// - Data port write loads tx_holding_buf; read returns rx_holding_buf.
// - baud_first_div codes 0..3 give factors 1, 3, 4, 13.
// - Transmit divisor is two to tx_div_code unless tx_fine_div is nonzero.
// - Receive divisor is two to rx_div_code unless rx_fine_div is nonzero.
// - Conventional rate is core clock over 32 times prefactor times divisor.
// - Nonzero fine divider gives core clock over 16 times its value; resets to zero.
// - Line data travels least significant bit first.
`timescale 1ns/10ps
module asrb_top (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	input wire logic rx_pin_i,
	output logic tx_pin_o,
	output logic tx_pin_en_o,
	output logic irq_o
);
	typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} asrb_rx_state_t;

	typedef struct packed {
		logic [7:0] rd_data;
		logic irq;
		logic [6:0] flags;
		logic [6:0] arm;
		logic [7:0] irq_ctl;
		logic [7:0] baud;
		logic [7:0] tx_fine;
		logic [7:0] rx_fine;
		logic rx9;
		logic tx9;
		logic nine;
		logic rouse;
		logic [7:0] tx_hold;
		logic [7:0] rx_hold;
		logic [1:0] sync;
		logic [11:0] tx_cnt;
		logic [11:0] rx_cnt;
		logic tx_busy;
		logic [3:0] tx_sub;
		logic [3:0] tx_bits;
		logic [10:0] tx_shift;
		logic tx_line;
		logic pre_pend;
		logic brk_pend;
		asrb_rx_state_t rx_state;
		logic [3:0] rx_sub;
		logic [3:0] rx_bits;
		logic [8:0] rx_shift;
		logic v0;
		logic v1;
		logic rx_noise;
		logic [7:0] idle_cnt;
		logic idle_armed;
	} asrb_state_t;

	asrb_state_t q;
	asrb_state_t next_q;

	logic [11:0] pre;
	logic [11:0] tx_per;
	logic [11:0] rx_per;
	logic tx_tick;
	logic rx_tick;
	logic line;
	logic maj;
	logic noisy;
	logic keep_word;
	logic load_data;
	logic word_done;
	logic idle_evt;
	logic [7:0] idle_subs;

	always_comb
	begin
		next_q = q;
		load_data = 1'b0;
		word_done = 1'b0;
		idle_evt = 1'b0;
		keep_word = 1'b0;
		line = q.sync[1];
		next_q.sync = {q.sync[0], rx_pin_i};
		idle_subs = q.nine ? asrb_pkg::IDLE_SUBS9 : asrb_pkg::IDLE_SUBS8;

		// Bit-rate dividers produce one sub-tick per sixteenth of a bit
		unique case (q.baud[asrb_pkg::B_PRE_HI:asrb_pkg::B_PRE_LO])
			2'b00: pre = asrb_pkg::PRE_F0;
			2'b01: pre = asrb_pkg::PRE_F1;
			2'b10: pre = asrb_pkg::PRE_F2;
			2'b11: pre = asrb_pkg::PRE_F3;
		endcase
		tx_per = (q.tx_fine != 8'h00) ? {4'h0, q.tx_fine} :
			12'((pre << asrb_pkg::CONV_SHIFT) << q.baud[asrb_pkg::B_TX_HI:asrb_pkg::B_TX_LO]);
		rx_per = (q.rx_fine != 8'h00) ? {4'h0, q.rx_fine} :
			12'((pre << asrb_pkg::CONV_SHIFT) << q.baud[asrb_pkg::B_RX_HI:asrb_pkg::B_RX_LO]);
		// Compare with >= so a divisor shrunk mid-count cannot strand the counter
		tx_tick = q.tx_cnt >= (tx_per - 12'h001);
		rx_tick = q.rx_cnt >= (rx_per - 12'h001);
		next_q.tx_cnt = tx_tick ? 12'h000 : q.tx_cnt + 12'h001;
		next_q.rx_cnt = rx_tick ? 12'h000 : q.rx_cnt + 12'h001;

		// Register reads: data stands one cycle after the strobe only
		next_q.rd_data = 8'h00;
		if (rd_i)
		begin
			unique case (addr_i)
				asrb_pkg::ADDR_FLAG: next_q.rd_data = {q.flags, 1'b0};
				asrb_pkg::ADDR_DATA: next_q.rd_data = q.rx_hold;
				asrb_pkg::ADDR_BAUD: next_q.rd_data = q.baud;
				asrb_pkg::ADDR_CHAR: next_q.rd_data = {q.rx9, q.tx9, 1'b0, q.nine, q.rouse, 3'b000};
				asrb_pkg::ADDR_IRQ: next_q.rd_data = q.irq_ctl;
				asrb_pkg::ADDR_RXFINE: next_q.rd_data = q.rx_fine;
				asrb_pkg::ADDR_TXFINE: next_q.rd_data = q.tx_fine;
				default: next_q.rd_data = 8'h00;
			endcase
			if (addr_i == asrb_pkg::ADDR_FLAG)
				next_q.arm = q.flags;
			if (addr_i == asrb_pkg::ADDR_DATA)
			begin
				next_q.flags = q.flags & ~(q.arm & asrb_pkg::RX_FLAG_MASK);
				next_q.arm = 7'h00;
			end
		end
		if (wr_i)
		begin
			unique case (addr_i)
				asrb_pkg::ADDR_DATA:
				begin
					next_q.tx_hold = wr_data_i;
					next_q.flags = q.flags & ~(q.arm & asrb_pkg::TX_FLAG_MASK);
					next_q.arm = 7'h00;
				end
				asrb_pkg::ADDR_BAUD: next_q.baud = wr_data_i;
				asrb_pkg::ADDR_CHAR:
				begin
					next_q.tx9 = wr_data_i[asrb_pkg::C_TX9];
					next_q.nine = wr_data_i[asrb_pkg::C_NINE];
					next_q.rouse = wr_data_i[asrb_pkg::C_ROUSE];
				end
				asrb_pkg::ADDR_IRQ:
				begin
					next_q.irq_ctl = wr_data_i;
					// Re-enable while a frame is on the line queues a preamble
					if (wr_data_i[asrb_pkg::I_TXON] && !q.irq_ctl[asrb_pkg::I_TXON] && q.tx_busy)
						next_q.pre_pend = 1'b1;
					if (wr_data_i[asrb_pkg::I_BRK])
						next_q.brk_pend = 1'b1;
				end
				asrb_pkg::ADDR_RXFINE: next_q.rx_fine = wr_data_i;
				asrb_pkg::ADDR_TXFINE: next_q.tx_fine = wr_data_i;
				default: next_q.tx_hold = q.tx_hold;
			endcase
		end

		// Transmitter; hardware sets come after the software clears so a set wins
		if (q.tx_busy)
		begin
			if (tx_tick)
			begin
				next_q.tx_sub = q.tx_sub + 4'h1;
				if (q.tx_sub == asrb_pkg::SUB_LAST)
				begin
					next_q.tx_shift = {1'b1, q.tx_shift[10:1]};
					next_q.tx_bits = q.tx_bits - 4'h1;
					if (q.tx_bits == 4'h1)
					begin
						next_q.tx_busy = 1'b0;
						next_q.flags[asrb_pkg::F_DONE] = 1'b1;
					end
				end
			end
		end
		else if (q.irq_ctl[asrb_pkg::I_TXON])
		begin
			next_q.tx_sub = 4'h0;
			next_q.tx_bits = q.nine ? asrb_pkg::FRAME_BITS9 : asrb_pkg::FRAME_BITS8;
			if (q.brk_pend || q.irq_ctl[asrb_pkg::I_BRK])
			begin
				next_q.tx_shift = 11'h000;
				next_q.brk_pend = 1'b0;
				next_q.tx_busy = 1'b1;
			end
			else if (q.pre_pend)
			begin
				next_q.tx_shift = 11'h7ff;
				next_q.pre_pend = 1'b0;
				next_q.tx_busy = 1'b1;
			end
			else if (!q.flags[asrb_pkg::F_VAC])
			begin
				load_data = 1'b1;
				next_q.tx_shift = {1'b1, q.nine ? q.tx9 : 1'b1, q.tx_hold, 1'b0};
				next_q.flags[asrb_pkg::F_VAC] = 1'b1;
				next_q.tx_busy = 1'b1;
			end
		end
		next_q.tx_line = next_q.tx_busy ? next_q.tx_shift[0] : 1'b1;

		// Receiver: three votes around mid-bit; a false start returns to hunting
		maj = (q.v0 & q.v1) | (q.v0 & line) | (q.v1 & line);
		noisy = !((q.v0 == q.v1) && (q.v1 == line));
		if (!q.irq_ctl[asrb_pkg::I_RXON])
		begin
			next_q.rx_state = RX_HUNT;
			next_q.idle_cnt = 8'h00;
			next_q.flags = next_q.flags & ~asrb_pkg::RX_FLAG_MASK;
		end
		else if (rx_tick)
		begin
			if ((q.rx_state == RX_HUNT) && line)
			begin
				if (q.idle_cnt != idle_subs)
					next_q.idle_cnt = q.idle_cnt + 8'h01;
				idle_evt = q.idle_cnt == (idle_subs - 8'h01);
			end
			else
				next_q.idle_cnt = 8'h00;
			if (idle_evt)
			begin
				if (q.irq_ctl[asrb_pkg::I_SILENT])
				begin
					if (!q.rouse)
						next_q.irq_ctl[asrb_pkg::I_SILENT] = 1'b0;
				end
				else if (q.idle_armed)
				begin
					next_q.flags[asrb_pkg::F_IDLE] = 1'b1;
					next_q.idle_armed = 1'b0;
				end
			end
			if (q.rx_state == RX_HUNT)
			begin
				if (!line)
				begin
					next_q.rx_state = RX_START;
					next_q.rx_sub = 4'h0;
					next_q.rx_noise = 1'b0;
				end
			end
			else
			begin
				next_q.rx_sub = q.rx_sub + 4'h1;
				if (q.rx_sub == asrb_pkg::SUB_S0)
					next_q.v0 = line;
				if (q.rx_sub == asrb_pkg::SUB_S1)
					next_q.v1 = line;
				if (q.rx_sub == asrb_pkg::SUB_S2)
				begin
					next_q.rx_noise = q.rx_noise | noisy;
					if ((q.rx_state == RX_START) && maj)
						next_q.rx_state = RX_HUNT;
					if (q.rx_state == RX_DATA)
						next_q.rx_shift = {maj, q.rx_shift[8:1]};
					if (q.rx_state == RX_STOP)
					begin
						word_done = 1'b1;
						next_q.rx_state = RX_HUNT;
					end
				end
				if (q.rx_sub == asrb_pkg::SUB_LAST)
				begin
					if (q.rx_state == RX_START)
					begin
						next_q.rx_state = RX_DATA;
						next_q.rx_bits = 4'h0;
					end
					else if (q.rx_state == RX_DATA)
					begin
						next_q.rx_bits = q.rx_bits + 4'h1;
						if (q.rx_bits == (q.nine ? asrb_pkg::DATA_LAST9 : asrb_pkg::DATA_LAST8))
							next_q.rx_state = RX_STOP;
					end
				end
			end
		end

		// Finished word; the top shift bit is the msb in both word lengths
		if (word_done)
		begin
			keep_word = !q.irq_ctl[asrb_pkg::I_SILENT] || (q.rouse && q.rx_shift[8]);
			if (q.irq_ctl[asrb_pkg::I_SILENT] && keep_word)
				next_q.irq_ctl[asrb_pkg::I_SILENT] = 1'b0;
			if (keep_word)
			begin
				if (q.flags[asrb_pkg::F_FULL])
					next_q.flags[asrb_pkg::F_LOST] = 1'b1;
				else
				begin
					next_q.rx_hold = q.nine ? q.rx_shift[7:0] : q.rx_shift[8:1];
					if (q.nine)
						next_q.rx9 = q.rx_shift[8];
					next_q.flags[asrb_pkg::F_FULL] = 1'b1;
					next_q.flags[asrb_pkg::F_NOISE] = next_q.flags[asrb_pkg::F_NOISE] |
						q.rx_noise | noisy;
					next_q.flags[asrb_pkg::F_FRAME] = next_q.flags[asrb_pkg::F_FRAME] | !maj;
					next_q.idle_armed = 1'b1;
				end
			end
		end

		next_q.irq = (next_q.irq_ctl[asrb_pkg::I_TXVOID] & next_q.flags[asrb_pkg::F_VAC]) |
			(next_q.irq_ctl[asrb_pkg::I_TXDONE] & next_q.flags[asrb_pkg::F_DONE]) |
			(next_q.irq_ctl[asrb_pkg::I_RX] &
			(next_q.flags[asrb_pkg::F_FULL] | next_q.flags[asrb_pkg::F_LOST])) |
			(next_q.irq_ctl[asrb_pkg::I_IDLE] & next_q.flags[asrb_pkg::F_IDLE]);
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			q <= '0;
			q.flags <= asrb_pkg::FLAG_RST[7:1];
			q.irq_ctl <= asrb_pkg::IRQ_RST;
			q.baud <= asrb_pkg::BAUD_RST;
			q.tx_fine <= asrb_pkg::FINE_RST;
			q.rx_fine <= asrb_pkg::FINE_RST;
			q.rx9 <= asrb_pkg::CHAR_RST[asrb_pkg::C_RX9];
			q.tx9 <= asrb_pkg::CHAR_RST[asrb_pkg::C_TX9];
			q.nine <= asrb_pkg::CHAR_RST[asrb_pkg::C_NINE];
			q.rouse <= asrb_pkg::CHAR_RST[asrb_pkg::C_ROUSE];
			q.sync <= 2'b11;
			q.tx_line <= 1'b1;
			q.rx_state <= RX_HUNT;
		end
		else
			q <= next_q;
	end

	assign rd_data_o = q.rd_data;
	assign irq_o = q.irq;
	assign tx_pin_o = q.tx_line;
	assign tx_pin_en_o = q.irq_ctl[asrb_pkg::I_TXON];

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_full_armed;
		rd_i && (addr_i == asrb_pkg::ADDR_FLAG) && q.flags[asrb_pkg::F_FULL];
	endsequence
	sequence s_data_read_quiet;
		rd_i && !wr_i && (addr_i == asrb_pkg::ADDR_DATA) && !word_done;
	endsequence
	sequence s_data_frame_start;
		$rose(q.tx_busy) && (q.tx_shift[10] == 1'b1) && (q.tx_shift != 11'h7ff);
	endsequence

	a_load_needs_write: assert property (load_data |-> !q.flags[asrb_pkg::F_VAC])
		else $error("holding data moved while vacant flag set");
	a_load_sets_vacant: assert property (load_data |=> q.flags[asrb_pkg::F_VAC] && q.tx_busy)
		else $error("vacant flag not set after load");
	a_frame_done_flag: assert property ($fell(q.tx_busy) |-> q.flags[asrb_pkg::F_DONE])
		else $error("frame ended without done flag");
	a_start_bit_low: assert property (s_data_frame_start |-> !tx_pin_o ##1 !tx_pin_o)
		else $error("data frame did not open with start bit");
	a_idle_line_high: assert property (!q.tx_busy |-> tx_pin_o)
		else $error("line not idle high between frames");
	a_full_seq_clear: assert property (s_full_armed ##1 s_data_read_quiet |=> !q.flags[asrb_pkg::F_FULL])
		else $error("read sequence did not clear full flag");
	a_rx_off_clears: assert property (wr_i && (addr_i == asrb_pkg::ADDR_IRQ) && !wr_data_i[asrb_pkg::I_RXON]
		|=> ##1 ((q.flags & asrb_pkg::RX_FLAG_MASK) == 7'h00))
		else $error("receive flags survived receiver disable");
	a_overrun_keeps: assert property (word_done && keep_word && q.flags[asrb_pkg::F_FULL]
		|=> q.flags[asrb_pkg::F_LOST] && (q.rx_hold == $past(q.rx_hold)))
		else $error("overrun lost flag or holding word wrong");
	a_irq_from_flags: assert property (irq_o == ((q.irq_ctl[asrb_pkg::I_RX] && q.flags[asrb_pkg::F_FULL]) ||
		(q.irq_ctl[asrb_pkg::I_RX] && q.flags[asrb_pkg::F_LOST]) ||
		(q.irq_ctl[asrb_pkg::I_TXVOID] && q.flags[asrb_pkg::F_VAC]) ||
		(q.irq_ctl[asrb_pkg::I_TXDONE] && q.flags[asrb_pkg::F_DONE]) ||
		(q.irq_ctl[asrb_pkg::I_IDLE] && q.flags[asrb_pkg::F_IDLE])))
		else $error("interrupt output disagrees with flags");
endmodule

// ---- asrb_peer.sv ----
// Remote serial transceiver model: sends frames on the receive line, decodes the transmit line.
// Assumes an idle-high line and a bit time in core clocks given by the bench.
`timescale 1ns/10ps
module asrb_peer (
	input wire logic clock_i,
	input wire logic tx_pin_i,
	input wire logic tx_en_i,
	input wire logic nine_i,
	input wire logic [7:0] bit_clks_i,
	output logic rx_line_o,
	output logic got_o,
	output logic [9:0] word_o
);
	logic line;
	logic [9:0] sh;
	int n;
	// A pin not owned by the serial function is pulled high
	assign line = tx_en_i ? tx_pin_i : 1'b1;
	initial
	begin
		rx_line_o = 1'b1;
		got_o = 1'b0;
		word_o = 10'h000;
	end
	// Stop level is a choice so that broken frames can be sent on purpose
	task automatic send(input logic [7:0] d, input logic b9, input logic stop);
		logic [10:0] f;
		f = nine_i ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
		for (int k = 0; k < (nine_i ? 11 : 10); k++)
		begin
			rx_line_o <= f[k];
			repeat (bit_clks_i) @(posedge clock_i);
		end
		rx_line_o <= 1'b1;
	endtask
	// Word is reported as stop level, ninth bit, data
	initial
	forever
	begin
		@(posedge clock_i);
		if (got_o)
			got_o <= 1'b0;
		else if (line === 1'b0)
		begin
			repeat (bit_clks_i / 2) @(posedge clock_i);
			n = nine_i ? 10 : 9;
			sh = 10'h000;
			for (int k = 0; k < n; k++)
			begin
				repeat (bit_clks_i) @(posedge clock_i);
				sh[k] = line;
			end
			// A break holds the line low; report only once it returns high
			// Bounded so a stuck-low line cannot hang the model
			for (int w = 0; w < 4096 && line !== 1'b1; w++)
				@(posedge clock_i);
			word_o <= nine_i ? sh : {sh[8], 1'b0, sh[7:0]};
			got_o <= 1'b1;
		end
	end
endmodule

// ---- asrb_top_test.sv ----
// Self-checking bench for the serial block: register master plus a peer on the line.
// Assumes the peer model asrb_peer and a 250 MHz core clock.
`timescale 1ns/10ps
module asrb_top_test;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdat = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic nine = 1'b0;
	logic [7:0] bclk = 8'h20;
	logic [7:0] rd_data;
	logic rx_line;
	logic tx_pin;
	logic tx_en;
	logic irq;
	logic got;
	logic [9:0] word;
	logic [7:0] d;
	logic [7:0] d2;
	int seed = 32'h96a9d441;
	int errors = 0;
	int total_checks = 0;
	logic [7:0] rd_q[$];
	logic [9:0] tx_q[$];

	always #2 clock_i = ~clock_i;

	asrb_top dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr), .wr_data_i(wdat),
		.wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .rx_pin_i(rx_line), .tx_pin_o(tx_pin),
		.tx_pin_en_o(tx_en), .irq_o(irq));
	asrb_peer peer (.clock_i(clock_i), .tx_pin_i(tx_pin), .tx_en_i(tx_en), .nine_i(nine),
		.bit_clks_i(bclk), .rx_line_o(rx_line), .got_o(got), .word_o(word));

	task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Strobes stay up between back-to-back accesses; idle and send drop them
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdat <= v;
		rd <= 1'b0;
		wr <= 1'b1;
		@(posedge clock_i);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock_i);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clock_i);
	endtask
	task automatic send(input logic [7:0] v, input logic b9, input logic stop);
		wr <= 1'b0;
		rd <= 1'b0;
		peer.send(v, b9, stop);
	endtask
	task automatic wait_tx;
		int n;
		n = 0;
		wr <= 1'b0;
		rd <= 1'b0;
		while (tx_q.size() > 0 && n < 1000)
		begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 1000)
		begin
			chk("line word wait", 10'h000, 10'h001);
			test_done;
		end
	endtask

	// Read data stands only in the cycle after the strobe; a stray line word is a mismatch
	always @(posedge clock_i)
	begin
		rd_d <= rd;
		if (rd_d)
			chk("rd_data", {2'b00, rd_q.pop_front()}, {2'b00, rd_data});
		if (got)
			chk("line word", (tx_q.size() > 0) ? tx_q.pop_front() : 10'h3ff, word);
	end

	initial
	begin
		repeat (8) @(posedge clock_i);
		reset_n_i <= 1'b1;
		@(posedge clock_i);
		chk("tx_pin", 10'h001, {9'h000, tx_pin});
		chk("tx_en", 10'h000, {9'h000, tx_en});
		chk("irq", 10'h000, {9'h000, irq});
		rreg(asrb_pkg::ADDR_IRQ, 8'h00);
		rreg(asrb_pkg::ADDR_BAUD, 8'h00);
		rreg(asrb_pkg::ADDR_CHAR, 8'h00);
		rreg(asrb_pkg::ADDR_RXFINE, 8'h00);
		rreg(asrb_pkg::ADDR_TXFINE, 8'h00);
		rreg(8'h56, 8'h00);
		wreg(asrb_pkg::ADDR_IRQ, 8'h88);
		idle(3);
		chk("tx_en", 10'h001, {9'h000, tx_en});
		chk("irq", 10'h001, {9'h000, irq});
		// Unarmed write loads the buffer but must not start a frame
		wreg(asrb_pkg::ADDR_DATA, 8'h5a);
		idle(300);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		d = $random(seed);
		tx_q.push_back({2'b10, d});
		wreg(asrb_pkg::ADDR_DATA, d);
		idle(3);
		rreg(asrb_pkg::ADDR_FLAG, 8'h80);
		wait_tx;
		idle(40);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		d2 = $random(seed);
		wreg(asrb_pkg::ADDR_BAUD, d2);
		rreg(asrb_pkg::ADDR_BAUD, d2);
		wreg(asrb_pkg::ADDR_TXFINE, 8'h01);
		wreg(asrb_pkg::ADDR_RXFINE, 8'h01);
		wreg(asrb_pkg::ADDR_CHAR, 8'h50);
		nine = 1'b1;
		bclk = 8'h10;
		d = $random(seed);
		tx_q.push_back({2'b11, d});
		wreg(asrb_pkg::ADDR_DATA, d);
		wait_tx;
		idle(40);
		wreg(asrb_pkg::ADDR_CHAR, 8'h00);
		nine = 1'b0;
		tx_q.push_back(10'h000);
		wreg(asrb_pkg::ADDR_IRQ, 8'h89);
		wreg(asrb_pkg::ADDR_IRQ, 8'h88);
		wait_tx;
		idle(40);
		wreg(asrb_pkg::ADDR_IRQ, 8'h2c);
		idle(3);
		chk("irq", 10'h000, {9'h000, irq});
		d = $random(seed);
		send(d, 1'b0, 1'b1);
		idle(20);
		chk("irq", 10'h001, {9'h000, irq});
		rreg(asrb_pkg::ADDR_FLAG, 8'he0);
		rreg(asrb_pkg::ADDR_DATA, d);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		idle(200);
		rreg(asrb_pkg::ADDR_FLAG, 8'hd0);
		rreg(asrb_pkg::ADDR_DATA, d);
		idle(200);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		// Second word lands while the first is still unread
		d = $random(seed);
		d2 = $random(seed);
		send(d, 1'b0, 1'b1);
		send(d2, 1'b0, 1'b1);
		idle(20);
		rreg(asrb_pkg::ADDR_FLAG, 8'he8);
		rreg(asrb_pkg::ADDR_DATA, d);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		send(8'h00, 1'b0, 1'b0);
		idle(20);
		rreg(asrb_pkg::ADDR_FLAG, 8'he2);
		wreg(asrb_pkg::ADDR_IRQ, 8'h08);
		idle(3);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		wreg(asrb_pkg::ADDR_IRQ, 8'h0c);
		wreg(asrb_pkg::ADDR_CHAR, 8'h10);
		nine = 1'b1;
		d = $random(seed);
		send(d, 1'b1, 1'b1);
		idle(20);
		rreg(asrb_pkg::ADDR_CHAR, 8'h90);
		rreg(asrb_pkg::ADDR_FLAG, 8'he0);
		rreg(asrb_pkg::ADDR_DATA, d);
		// Muted receiver drops plain words and wakes on an address mark
		nine = 1'b0;
		wreg(asrb_pkg::ADDR_CHAR, 8'h08);
		wreg(asrb_pkg::ADDR_IRQ, 8'h0e);
		send(8'h12, 1'b0, 1'b1);
		idle(20);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		send(8'h92, 1'b0, 1'b1);
		idle(20);
		rreg(asrb_pkg::ADDR_IRQ, 8'h0c);
		rreg(asrb_pkg::ADDR_FLAG, 8'he0);
		rreg(asrb_pkg::ADDR_DATA, 8'h92);
		idle(3);
		// Idle-line wake clears mute but must not raise the idle flag
		wreg(asrb_pkg::ADDR_CHAR, 8'h00);
		wreg(asrb_pkg::ADDR_IRQ, 8'h0e);
		idle(200);
		rreg(asrb_pkg::ADDR_IRQ, 8'h0c);
		rreg(asrb_pkg::ADDR_FLAG, 8'hc0);
		// Conventional receive rate: factor 3, divisor 2, so 192 clocks a bit
		wreg(asrb_pkg::ADDR_RXFINE, 8'h00);
		wreg(asrb_pkg::ADDR_BAUD, 8'h41);
		bclk = 8'hc0;
		d = $random(seed);
		send(d, 1'b0, 1'b1);
		idle(20);
		rreg(asrb_pkg::ADDR_FLAG, 8'he0);
		rreg(asrb_pkg::ADDR_DATA, d);
		idle(3);
		test_done;
	end
endmodule
